/* File: shared/mca_pkg.sv */
// Shared constants, timing counts and state type for the memory card host controller.
package mca_pkg;
  // ==========================================================================
  // Bus shape
  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;
  localparam int CNT_W = 8;

  // ==========================================================================
  // Clock
  localparam int CLK_NS = 50;

  // ==========================================================================
  // Card cycle times in ns
  localparam int ADDR_SU_NS = 30;
  localparam int ADDR_HOLD_NS = 20;
  localparam int CMN_ACC_NS = 250;
  localparam int ATR_ACC_NS = 300;
  localparam int WR_PULSE_NS = 150;
  localparam int WR_REC_NS = 30;
  localparam int OE_DIS_NS = 100;
  localparam int WAIT_MAX_NS = 12000;

  // ==========================================================================
  // Cycle counts; least times round up, the longest wait rounds down
  localparam int ADDR_SU_CYC = (ADDR_SU_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CMN_STB_CYC = (CMN_ACC_NS - ADDR_SU_CYC * CLK_NS + CLK_NS - 1) / CLK_NS;
  localparam int ATR_STB_CYC = (ATR_ACC_NS - ADDR_SU_CYC * CLK_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_PULSE_CYC = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_REC_CYC = (WR_REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int OE_DIS_CYC = (OE_DIS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAIT_MAX_CYC = WAIT_MAX_NS / CLK_NS;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    MCA_IDLE,
    MCA_SETUP,
    MCA_STROBE,
    MCA_HOLD,
    MCA_TURN
  } mca_state_t;
endpackage : mca_pkg

/* File: rtl/mca_tmr.sv */
// Down counter that times each phase of a card cycle.
`timescale 1ns/1ns
module mca_tmr #(
  parameter int CNT_W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  output logic zero
);
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign zero = (cnt_r == '0);
endmodule : mca_tmr

/* File: rtl/mca_host.sv */
// Host socket controller that runs read and write cycles on a memory card bus.
`timescale 1ns/1ns
module mca_host #(
  parameter int WAIT_TMO_CYC = mca_pkg::WAIT_MAX_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_attr,
  input wire logic req_word,
  input wire logic [mca_pkg::ADDR_W-1:0] req_addr,
  input wire logic [mca_pkg::DATA_W-1:0] req_wdata,
  input wire logic wait_en,
  output logic req_ready,
  output logic [mca_pkg::DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic wait_tmo,
  output logic [mca_pkg::ADDR_W-1:0] addr_lines,
  output logic attr_sel_n,
  output logic card_sel_low_n,
  output logic card_sel_high_n,
  output logic out_en_n,
  output logic write_strobe_n,
  input wire logic [mca_pkg::DATA_W-1:0] data_lines_i,
  output logic [mca_pkg::DATA_W-1:0] data_lines_o,
  output logic data_lines_oe_n,
  input wire logic wait_n
);
  localparam int CW = mca_pkg::CNT_W;

  // ==========================================================================
  // Elaboration checks
  if (WAIT_TMO_CYC < 1 || WAIT_TMO_CYC >= (1 << CW)) begin : g_chk_tmo
    $error("WAIT_TMO_CYC out of range");
  end
  if (mca_pkg::ATR_STB_CYC >= (1 << CW) || mca_pkg::OE_DIS_CYC >= (1 << CW)) begin : g_chk_cnt
    $error("phase count exceeds timer width");
  end

  localparam logic [CW-1:0] SU_V = CW'(mca_pkg::ADDR_SU_CYC - 1);
  localparam logic [CW-1:0] CMN_STB_V = CW'(mca_pkg::CMN_STB_CYC - 1);
  localparam logic [CW-1:0] ATR_STB_V = CW'(mca_pkg::ATR_STB_CYC - 1);
  localparam logic [CW-1:0] WR_STB_V = CW'(mca_pkg::WR_PULSE_CYC - 1);
  localparam logic [CW-1:0] RD_HOLD_V = CW'(mca_pkg::ADDR_HOLD_CYC - 1);
  localparam logic [CW-1:0] WR_HOLD_V = CW'(mca_pkg::WR_REC_CYC - 1);
  localparam logic [CW-1:0] TURN_V = CW'(mca_pkg::OE_DIS_CYC - 1);
  localparam logic [CW-1:0] TMO_V = CW'(WAIT_TMO_CYC);

  mca_pkg::mca_state_t state_r;
  logic wr_r;
  logic attr_r;
  logic [CW-1:0] wait_cnt_r;
  logic tmr_zero;
  logic tmr_load;
  logic [CW-1:0] tmr_val;
  logic take;
  logic su_end;
  logic stb_end;
  logic hold_end;
  logic turn_end;
  logic card_waits;
  logic tmo_hit;

  // ==========================================================================
  // Phase decode
  assign take = (state_r == mca_pkg::MCA_IDLE) && req_valid && req_ready;
  assign su_end = (state_r == mca_pkg::MCA_SETUP) && tmr_zero;
  assign card_waits = wait_en && !wait_n;
  assign tmo_hit = (wait_cnt_r >= TMO_V);
  // The wait line is only looked at once the least strobe time has run out.
  assign stb_end = (state_r == mca_pkg::MCA_STROBE) && tmr_zero && (!card_waits || tmo_hit);
  assign hold_end = (state_r == mca_pkg::MCA_HOLD) && tmr_zero;
  assign turn_end = (state_r == mca_pkg::MCA_TURN) && tmr_zero;

  always_comb begin
    tmr_load = 1'b0;
    tmr_val = '0;
    if (take) begin
      tmr_load = 1'b1;
      tmr_val = SU_V;
    end else if (su_end) begin
      tmr_load = 1'b1;
      if (wr_r) begin
        tmr_val = WR_STB_V;
      end else if (attr_r) begin
        tmr_val = ATR_STB_V;
      end else begin
        tmr_val = CMN_STB_V;
      end
    end else if (stb_end) begin
      tmr_load = 1'b1;
      tmr_val = wr_r ? WR_HOLD_V : RD_HOLD_V;
    end else if (hold_end && !wr_r) begin
      tmr_load = 1'b1;
      tmr_val = TURN_V;
    end
  end

  mca_tmr #(
    .CNT_W(CW)
  ) u_tmr (
    .mclk(mclk),
    .rst(rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .zero(tmr_zero)
  );

  // ==========================================================================
  // Sequencer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= mca_pkg::MCA_IDLE;
    end else begin
      case (state_r)
        mca_pkg::MCA_IDLE: begin
          if (take) begin
            state_r <= mca_pkg::MCA_SETUP;
          end
        end
        mca_pkg::MCA_SETUP: begin
          if (su_end) begin
            state_r <= mca_pkg::MCA_STROBE;
          end
        end
        mca_pkg::MCA_STROBE: begin
          if (stb_end) begin
            state_r <= mca_pkg::MCA_HOLD;
          end
        end
        mca_pkg::MCA_HOLD: begin
          if (hold_end) begin
            // After a read the card may still drive data; give it time to let go.
            state_r <= wr_r ? mca_pkg::MCA_IDLE : mca_pkg::MCA_TURN;
          end
        end
        mca_pkg::MCA_TURN: begin
          if (turn_end) begin
            state_r <= mca_pkg::MCA_IDLE;
          end
        end
        default: begin
          state_r <= mca_pkg::MCA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      req_ready <= 1'b0;
    end else if (take) begin
      req_ready <= 1'b0;
    end else if (state_r == mca_pkg::MCA_IDLE || (hold_end && wr_r) || turn_end) begin
      req_ready <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_r <= 1'b0;
      attr_r <= 1'b0;
    end else if (take) begin
      wr_r <= req_write;
      attr_r <= req_attr;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wait_cnt_r <= '0;
    end else if (su_end) begin
      wait_cnt_r <= '0;
    end else if (state_r == mca_pkg::MCA_STROBE && tmr_zero && card_waits && !tmo_hit) begin
      wait_cnt_r <= wait_cnt_r + 1'b1;
    end
  end

  // ==========================================================================
  // Card pins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_lines <= '0;
      attr_sel_n <= 1'b1;
      card_sel_low_n <= 1'b1;
      card_sel_high_n <= 1'b1;
    end else if (take) begin
      // All 26 lines are driven as given; A0 picks the byte lane in byte mode.
      addr_lines <= req_addr;
      attr_sel_n <= !req_attr;
      card_sel_low_n <= 1'b0;
      card_sel_high_n <= !req_word;
    end else if (hold_end) begin
      attr_sel_n <= 1'b1;
      card_sel_low_n <= 1'b1;
      card_sel_high_n <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_en_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else if (su_end) begin
      // Only one strobe per cycle; plain write cycles, no programming sequence.
      out_en_n <= wr_r;
      write_strobe_n <= !wr_r;
    end else if (stb_end) begin
      out_en_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      data_lines_o <= '0;
      data_lines_oe_n <= 1'b1;
    end else if (take && req_write) begin
      // Output enable has been high for the turnaround time by now.
      data_lines_o <= req_wdata;
      data_lines_oe_n <= 1'b0;
    end else if (hold_end) begin
      data_lines_oe_n <= 1'b1;
    end
  end

  // ==========================================================================
  // Results
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else if (stb_end && !wr_r) begin
      rd_data <= data_lines_i;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
      done <= 1'b0;
    end else begin
      rd_valid <= hold_end && !wr_r;
      done <= hold_end;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wait_tmo <= 1'b0;
    end else if (take) begin
      wait_tmo <= 1'b0;
    end else if (stb_end && card_waits) begin
      wait_tmo <= 1'b1;
    end
  end
endmodule : mca_host

/* File: tb/mca_host_sva.sv */
// Checker for the card bus pins of the host controller.
`timescale 1ns/1ns
module mca_host_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [mca_pkg::ADDR_W-1:0] addr_lines,
  input wire logic attr_sel_n,
  input wire logic card_sel_low_n,
  input wire logic out_en_n,
  input wire logic write_strobe_n,
  input wire logic data_lines_oe_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ==========
  // Strobes and bus ownership
  property p_rd_we; !out_en_n |-> write_strobe_n; endproperty
  a_rd_we: assert property (p_rd_we) else $error("strobe overlap in read");
  property p_wr_oe; !write_strobe_n |-> out_en_n; endproperty
  a_wr_oe: assert property (p_wr_oe) else $error("read strobe in write");
  property p_fight; !out_en_n |-> data_lines_oe_n; endproperty
  a_fight: assert property (p_fight) else $error("host drives data in read");
  // ==========
  // Strobe widths and holds
  property p_we_w; $fell(write_strobe_n) |-> !write_strobe_n [*3]; endproperty
  a_we_w: assert property (p_we_w) else $error("write strobe too short");
  property p_cm_acc; $fell(out_en_n) && attr_sel_n |-> !out_en_n [*4]; endproperty
  a_cm_acc: assert property (p_cm_acc) else $error("common read too short");
  property p_at_acc; $fell(out_en_n) && !attr_sel_n |-> !out_en_n [*5]; endproperty
  a_at_acc: assert property (p_at_acc) else $error("attribute read too short");
  property p_addr; !card_sel_low_n && !$past(card_sel_low_n) |-> $stable(addr_lines); endproperty
  a_addr: assert property (p_addr) else $error("address moved in cycle");
  property p_wr_hold; $rose(write_strobe_n) |-> !card_sel_low_n && !data_lines_oe_n; endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("no hold after write");
endmodule : mca_host_chk
bind mca_host mca_host_chk mca_host_chk_i (.*);

/* File: tb/mca_card.sv */
// Behavioural memory card answering the host controller's cycles.
`timescale 1ns/1ns
module mca_card (
  input wire logic mclk,
  input wire logic [mca_pkg::ADDR_W-1:0] addr_lines,
  input wire logic attr_sel_n,
  input wire logic card_sel_low_n,
  input wire logic card_sel_high_n,
  input wire logic out_en_n,
  input wire logic write_strobe_n,
  input wire logic [mca_pkg::DATA_W-1:0] data_lines_i,
  input wire logic [7:0] wait_len,
  output logic [mca_pkg::DATA_W-1:0] card_d,
  output logic card_en,
  output logic wait_n
);
  localparam int CMN = mca_pkg::CMN_ACC_NS / mca_pkg::CLK_NS;
  localparam int ATR = mca_pkg::ATR_ACC_NS / mca_pkg::CLK_NS;
  logic [15:0] cm [0:255];
  logic [15:0] am [0:255];
  logic [15:0] w, v, nw;
  logic [7:0] ix;
  int cnt = 0;
  int wcnt = 0;
  logic we_d = 1'b1;
  // Twenty-six lines cannot name a byte past 64 MB; the store starts at zero and repeats with
  // no holes, and line 0 is never used as a word index, so register N sits at base plus 2N.
  assign ix = addr_lines[8:1];
  assign w = attr_sel_n ? cm[ix] : am[ix];
  assign v = !card_sel_high_n ? w : {8'h00, addr_lines[0] ? w[15:8] : w[7:0]};
  assign nw = !card_sel_high_n ? data_lines_i : addr_lines[0] ?
    {data_lines_i[7:0], w[7:0]} : {w[15:8], data_lines_i[7:0]};
  assign wait_n = !((!out_en_n || !write_strobe_n) && !card_sel_low_n && wcnt < wait_len);
  // Only memory cycles exist here, so no I/O cycle is ever answered.
  assign card_en = !card_sel_low_n && !out_en_n;
  // Before the access time the lines carry the inverse, so an early sample fails.
  assign card_d = (cnt >= (attr_sel_n ? CMN : ATR) - 1 && wait_n) ? v : ~v;
  always_ff @(posedge mclk) begin
    cnt <= card_sel_low_n ? 0 : cnt + 1;
    wcnt <= (out_en_n && write_strobe_n) ? 0 : wcnt + 1;
    we_d <= write_strobe_n;
    if (write_strobe_n && !we_d && !card_sel_low_n) begin
      if (attr_sel_n) begin
        cm[ix] <= nw;
      end else begin
        am[ix] <= nw;
      end
    end
  end
endmodule : mca_card

/* File: tb/tb_top.sv */
// Bench driving the host controller against a behavioural card.
`timescale 1ns/1ns
module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0, req_attr = 1'b0, req_word = 1'b1, wait_en = 1'b1;
  logic [mca_pkg::ADDR_W-1:0] req_addr = '0, addr_lines;
  logic [mca_pkg::DATA_W-1:0] req_wdata = '0, rd_data, data_lines_o, data_lines_i, card_d, q;
  logic req_ready, rd_valid, done, wait_tmo, attr_sel_n, card_sel_low_n, card_sel_high_n;
  logic out_en_n, write_strobe_n, data_lines_oe_n, wait_n, card_en;
  logic [7:0] wait_len = 8'h00;
  int err_total = 0;
  int cmp_count = 0;
  always #25 mclk = ~mclk;
  // Undriven data lines sit on their pull-downs; two drivers show as unknown.
  assign data_lines_i = !data_lines_oe_n ? (card_en ? 'x : data_lines_o) :
    (card_en ? card_d : '0);
  mca_host #(.WAIT_TMO_CYC(4)) mca_host_i (.*);
  mca_card mca_card_i (.*);
  task automatic stop_test;
    $display("errors %0d, comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  task automatic cmp_v(input logic [25:0] g, input logic [25:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp_v
  task automatic cmp_n(input int g, input int e);
    cmp_count++;
    if (g != e) begin
      err_total++;
      $display("CHECK FAILED at %0t: %0d cycles, expected %0d", $time, g, e);
    end
  endtask : cmp_n
  task automatic fail;
    err_total++;
    $display("CHECK FAILED at %0t: no handshake", $time);
    stop_test();
  endtask : fail
  task automatic acc(input logic w, a, wd, input logic [25:0] ad, input logic [15:0] d,
                     input int ext);
    int n;
    int lat;
    // Edges from the take edge to the one that shows done: setup, strobe, hold.
    lat = mca_pkg::ADDR_SU_CYC + mca_pkg::ADDR_HOLD_CYC + ext
      + (w ? mca_pkg::WR_PULSE_CYC : a ? mca_pkg::ATR_STB_CYC : mca_pkg::CMN_STB_CYC);
    {req_write, req_attr, req_word, req_addr, req_wdata, req_valid} = {w, a, wd, ad, d, 1'b1};
    for (n = 0; req_ready !== 1'b1; n++) begin
      if (n > 20) fail();
      @(posedge mclk) #5;
    end
    @(posedge mclk) #5;
    req_valid = 1'b0;
    cmp_v(addr_lines, ad);
    n = 0;
    do begin
      @(posedge mclk) #5;
      n++;
      if (n > 300) fail();
    end while (done !== 1'b1);
    if (ext >= 0) cmp_n(n, lat);
    cmp_v(rd_valid, !w);
    q = rd_data;
  endtask : acc
  task automatic t_reset;
    repeat (4) @(posedge mclk);
    #5 cmp_v({out_en_n, write_strobe_n, card_sel_low_n, card_sel_high_n, attr_sel_n,
      data_lines_oe_n, req_ready, done, rd_valid, wait_tmo}, 26'h3f0);
    cmp_v(addr_lines, 26'h0);
    rst = 1'b0;
  endtask : t_reset
  task automatic t_mid_reset;
    int n;
    {req_write, req_attr, req_word, req_addr, req_valid} = {1'b0, 1'b0, 1'b1, 26'h10, 1'b1};
    for (n = 0; req_ready !== 1'b1; n++) begin
      if (n > 20) fail();
      @(posedge mclk) #5;
    end
    @(posedge mclk) #5;
    req_valid = 1'b0;
    repeat (2) @(posedge mclk);
    #5 rst = 1'b1;
    // A reset in mid read must drop both strobes and the low card select at once.
    #5 cmp_v({out_en_n, write_strobe_n, card_sel_low_n, data_lines_oe_n, req_ready}, 26'h1e);
    @(posedge mclk) #5;
    rst = 1'b0;
    acc(0, 0, 1, 26'h10, 16'h0000, 0);
    cmp_v(q, 16'h5a34);
  endtask : t_mid_reset
  task automatic t_word_byte;
    acc(1, 0, 1, 26'h200_0010, 16'h1234, 0);
    acc(0, 0, 1, 26'h200_0011, 16'h0000, 0);
    cmp_v(q, 16'h1234);
    acc(1, 0, 0, 26'h11, 16'h005a, 0);
    acc(0, 0, 1, 26'h10, 16'h0000, 0);
    cmp_v(q, 16'h5a34);
    acc(0, 0, 0, 26'h11, 16'h0000, 0);
    cmp_v(q, 16'h005a);
  endtask : t_word_byte
  task automatic t_attr;
    acc(1, 1, 1, 26'h20, 16'h00c3, 0);
    acc(0, 1, 1, 26'h20, 16'h0000, 0);
    cmp_v(q, 16'h00c3);
  endtask : t_attr
  task automatic t_wait;
    wait_len = 8'h06;
    acc(0, 0, 1, 26'h10, 16'h0000, 7 - mca_pkg::CMN_STB_CYC);
    cmp_v(q, 16'h5a34);
    acc(1, 0, 1, 26'h12, 16'hbeef, 7 - mca_pkg::WR_PULSE_CYC);
    wait_en = 1'b0;
    acc(0, 0, 1, 26'h12, 16'h0000, 0);
    // The card still holds wait, so its lines carry the inverse when sampled.
    cmp_v(q, 16'h4110);
    wait_en = 1'b1;
    wait_len = 8'h32;
    // The bench instance gives up after four extra strobe cycles.
    acc(0, 0, 1, 26'h12, 16'h0000, 4);
    cmp_v(wait_tmo, 1'b1);
    wait_len = 8'h00;
    acc(0, 0, 1, 26'h12, 16'h0000, 0);
    cmp_v({wait_tmo, q}, {1'b0, 16'hbeef});
  endtask : t_wait
  initial begin
    t_reset();
    t_word_byte();
    t_attr();
    t_wait();
    t_mid_reset();
    stop_test();
  end
endmodule : tb_top
